/* verilog/lcdfb_pkg.sv */
`default_nettype none
package lcdfb_pkg;

  // special function register addresses
  localparam logic [7:0] LCDFB_ADDR_CLK_BLINK = 8'h96;
  localparam logic [7:0] LCDFB_ADDR_INV_REF   = 8'hb1;

  // reset values
  localparam logic [7:0] LCDFB_RST_CLK_BLINK  = 8'h00;
  localparam logic [7:0] LCDFB_RST_INV_REF    = 8'h00;

  // field positions, clock and blink configuration register
  localparam int LCDFB_BLK_SRC_HI = 7;
  localparam int LCDFB_BLK_SRC_LO = 6;
  localparam int LCDFB_BLK_RATE_HI = 5;
  localparam int LCDFB_BLK_RATE_LO = 4;
  localparam int LCDFB_FD_HI = 3;
  localparam int LCDFB_FD_LO = 0;

  // field positions, inversion and refresh register
  localparam int LCDFB_INV_BIT = 6;
  localparam int LCDFB_UPD_BIT = 1;
  localparam int LCDFB_HOLD_BIT = 0;

  // width of the display data taken over per frame
  localparam int LCDFB_SEG_W = 32;

  // blink source codes
  localparam logic [1:0] LCDFB_BLK_SW_OFF = 2'h0;
  localparam logic [1:0] LCDFB_BLK_SW_ON  = 2'h1;
  localparam logic [1:0] LCDFB_BLK_2HZ    = 2'h2;
  localparam logic [1:0] LCDFB_BLK_RATE   = 2'h3;

  // multiplex level codes
  localparam logic [1:0] LCDFB_MUX_RSVD = 2'h0;
  localparam logic [1:0] LCDFB_MUX_2X   = 2'h1;
  localparam logic [1:0] LCDFB_MUX_3X   = 2'h2;
  localparam logic [1:0] LCDFB_MUX_4X   = 2'h3;

  // blink timing, counted in edges of the 128 hz source
  localparam int         LCDFB_BLINK_SRC_HZ = 128;
  localparam int         LCDFB_BLINK_FAST_HZ = 2;
  localparam logic [8:0] LCDFB_HALF_2HZ = 9'(LCDFB_BLINK_SRC_HZ / (2 * LCDFB_BLINK_FAST_HZ));
  localparam logic [8:0] LCDFB_HALF_1HZ = 9'(LCDFB_BLINK_SRC_HZ / 2);

  // frame divider figures, in source clock edges
  localparam logic [7:0] LCDFB_DIV_2X_CODE0 = 8'h80;
  localparam logic [7:0] LCDFB_DIV_34X_CODE0 = 8'h40;
  localparam logic [7:0] LCDFB_DIV_3X_CODE1 = 8'h06;
  localparam logic [7:0] LCDFB_DIV_LO_CODE15 = 8'h01;
  localparam logic [7:0] LCDFB_DIV_LO_CODE0 = 8'h02;
  localparam logic [7:0] LCDFB_DIV_LO_2X_C1 = 8'h04;
  localparam logic [7:0] LCDFB_DIV_LO_2X_C2 = 8'h06;
  localparam logic [7:0] LCDFB_DIV_LO_2X_MAX = 8'h08;
  localparam logic [7:0] LCDFB_DIV_LO_34X = 8'h04;

  // run state of the waveform timing
  typedef enum logic [1:0] {
    LCDFB_ST_IDLE = 2'b01,
    LCDFB_ST_RUN  = 2'b10
  } lcdfb_run_t;

  // register-side configuration
  typedef struct packed {
    logic [1:0] blink_source_sel;
    logic [1:0] blink_rate_sel;
    logic [3:0] frame_divider_code;
  } lcdfb_clkcfg_t;

  // timing outputs toward the segment and common drivers
  typedef struct packed {
    logic       drive_tick;
    logic [1:0] com_phase;
    logic       frame_start;
    logic       frame_polarity;
    logic       display_visible;
    logic       waveform_active;
  } lcdfb_timing_t;

endpackage
`default_nettype wire

/* verilog/lcdfb_shadow.sv */
`timescale 1ns/1ps
`default_nettype none
module lcdfb_shadow (
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  input  wire logic                               ce,
  input  wire logic                               load,
  input  wire logic [lcdfb_pkg::LCDFB_SEG_W-1:0]  din,
  output logic      [lcdfb_pkg::LCDFB_SEG_W-1:0]  dout
);

  typedef struct packed {
    logic [lcdfb_pkg::LCDFB_SEG_W-1:0] data;
  } lcdfb_shadow_st_t;

  lcdfb_shadow_st_t st_ff;
  lcdfb_shadow_st_t nxt_st;

  // take over the display data when loaded, else hold the last copy
  always_comb
  begin
    nxt_st = st_ff;
    if (load)
    begin
      nxt_st.data = din;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.data;

endmodule
`default_nettype wire

/* verilog/lcdfb_timing.sv */
`timescale 1ns/1ps
`default_nettype none
module lcdfb_timing (
  input  wire logic                               clk_sys,
  input  wire logic                               resetn,
  input  wire logic                               ce,
  input  wire logic [7:0]                         sfr_addr,
  input  wire logic [7:0]                         sfr_wdata,
  input  wire logic                               sfr_wr,
  input  wire logic                               sfr_rd,
  output logic      [7:0]                         sfr_rdata,
  input  wire logic                               driver_enable_bit,
  input  wire logic                               blink_enable_bit,
  input  wire logic                               source_clock_select,
  input  wire logic [1:0]                         multiplex_level,
  input  wire logic                               lcd_clk_2048,
  input  wire logic                               lcd_clk_128,
  input  wire logic [lcdfb_pkg::LCDFB_SEG_W-1:0]  display_data,
  output lcdfb_pkg::lcdfb_timing_t                timing,
  output logic      [lcdfb_pkg::LCDFB_SEG_W-1:0]  seg_data
);

  typedef struct packed {
    lcdfb_pkg::lcdfb_clkcfg_t clkcfg;
    logic                     frame_invert_en;
    logic                     refresh_hold;
    logic                     update_finished_flag;
    logic                     update_pending;
    lcdfb_pkg::lcdfb_run_t    run;
    logic [7:0]               div_cnt;
    logic [1:0]               phase;
    logic                     polarity;
    logic [8:0]               blink_cnt;
    logic                     blink_on;
    logic                     drive_tick;
    logic                     frame_start;
    logic                     load;
    logic [7:0]               rdata;
    logic [1:0]               sync_hi;
    logic [1:0]               sync_lo;
    logic                     prev_hi;
    logic                     prev_lo;
  } lcdfb_st_t;

  lcdfb_st_t st_ff;
  lcdfb_st_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  // source edges per drive period, per frame code, mux level and source
  function automatic logic [7:0] drive_div(
    input logic [3:0] code,
    input logic [1:0] mux,
    input logic       slow_src
  );
    logic [7:0] n1;
    n1 = {4'h0, code} + 8'h01;
    if (!slow_src && (mux == lcdfb_pkg::LCDFB_MUX_2X))
      drive_div = (code == 4'h0) ? lcdfb_pkg::LCDFB_DIV_2X_CODE0 : 8'(n1 << 2);
    else if (!slow_src && (code == 4'h0))
      drive_div = lcdfb_pkg::LCDFB_DIV_34X_CODE0;
    else if (!slow_src && (mux == lcdfb_pkg::LCDFB_MUX_3X) && (code == 4'h1))
      drive_div = lcdfb_pkg::LCDFB_DIV_3X_CODE1;
    else if (!slow_src)
      drive_div = 8'(n1 << 1);
    else if (code == 4'hf)
      drive_div = lcdfb_pkg::LCDFB_DIV_LO_CODE15;
    else if (code == 4'h0)
      drive_div = lcdfb_pkg::LCDFB_DIV_LO_CODE0;
    else if (mux != lcdfb_pkg::LCDFB_MUX_2X)
      drive_div = lcdfb_pkg::LCDFB_DIV_LO_34X;
    else if (code == 4'h1)
      drive_div = lcdfb_pkg::LCDFB_DIV_LO_2X_C1;
    else if (code == 4'h2)
      drive_div = lcdfb_pkg::LCDFB_DIV_LO_2X_C2;
    else
      drive_div = lcdfb_pkg::LCDFB_DIV_LO_2X_MAX;
  endfunction

  // half blink period in 128 hz edges
  function automatic logic [8:0] blink_half(
    input logic [1:0] src,
    input logic [1:0] rate
  );
    logic [8:0] mult;
    mult = {7'h00, rate} + 9'h001;
    if (src == lcdfb_pkg::LCDFB_BLK_2HZ)
    begin
      blink_half = lcdfb_pkg::LCDFB_HALF_2HZ;
    end
    else
    begin
      blink_half = 9'(lcdfb_pkg::LCDFB_HALF_1HZ * mult);
    end
  endfunction

  // last common phase of a frame for the mux level
  function automatic logic [1:0] last_phase(input logic [1:0] mux);
    case (mux)
      lcdfb_pkg::LCDFB_MUX_3X: last_phase = 2'h2;
      lcdfb_pkg::LCDFB_MUX_4X: last_phase = 2'h3;
      default:                 last_phase = 2'h1;
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync_ff <= 2'h0;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  logic       hi_edge;
  logic       lo_edge;
  logic       src_edge;
  logic       mux_ok;
  logic [7:0] div_now;
  logic       wr_clk;
  logic       wr_ref;
  logic       blinking;

  // edge detection on the synchronised source clocks
  assign hi_edge  = st_ff.sync_hi[1] & ~st_ff.prev_hi;
  assign lo_edge  = st_ff.sync_lo[1] & ~st_ff.prev_lo;
  assign src_edge = source_clock_select ? lo_edge : hi_edge;
  assign mux_ok   = (multiplex_level != lcdfb_pkg::LCDFB_MUX_RSVD);
  assign div_now  = drive_div(st_ff.clkcfg.frame_divider_code, multiplex_level,
                              source_clock_select);
  assign wr_clk   = sfr_wr & (sfr_addr == lcdfb_pkg::LCDFB_ADDR_CLK_BLINK);
  assign wr_ref   = sfr_wr & (sfr_addr == lcdfb_pkg::LCDFB_ADDR_INV_REF);
  assign blinking = st_ff.clkcfg.blink_source_sel[1];

  // next state of the whole block
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.sync_hi = {st_ff.sync_hi[0], lcd_clk_2048};
    nxt_st.sync_lo = {st_ff.sync_lo[0], lcd_clk_128};
    nxt_st.prev_hi = st_ff.sync_hi[1];
    nxt_st.prev_lo = st_ff.sync_lo[1];
    nxt_st.drive_tick = 1'b0;
    nxt_st.frame_start = 1'b0;
    nxt_st.load = 1'b0;

    // register writes; reserved bits are stored as zero
    if (wr_clk)
    begin
      nxt_st.clkcfg = sfr_wdata;
    end
    if (wr_ref)
    begin
      nxt_st.frame_invert_en = sfr_wdata[lcdfb_pkg::LCDFB_INV_BIT];
      nxt_st.refresh_hold = sfr_wdata[lcdfb_pkg::LCDFB_HOLD_BIT];
      if (sfr_wdata[lcdfb_pkg::LCDFB_HOLD_BIT] && !st_ff.refresh_hold)
      begin
        nxt_st.update_finished_flag = 1'b0;
        nxt_st.update_pending = 1'b1;
      end
    end

    // register reads, unmapped addresses answer zero
    if (sfr_rd)
    begin
      case (sfr_addr)
        lcdfb_pkg::LCDFB_ADDR_CLK_BLINK: nxt_st.rdata = st_ff.clkcfg;
        lcdfb_pkg::LCDFB_ADDR_INV_REF:
        begin
          nxt_st.rdata = 8'h00;
          nxt_st.rdata[lcdfb_pkg::LCDFB_INV_BIT] = st_ff.frame_invert_en;
          nxt_st.rdata[lcdfb_pkg::LCDFB_UPD_BIT] = st_ff.update_finished_flag;
          nxt_st.rdata[lcdfb_pkg::LCDFB_HOLD_BIT] = st_ff.refresh_hold;
        end
        default: nxt_st.rdata = 8'h00;
      endcase
    end

    // frame divider and common phase sequencing
    case (st_ff.run)
      lcdfb_pkg::LCDFB_ST_IDLE:
      begin
        nxt_st.div_cnt = 8'h00;
        nxt_st.phase = 2'h0;
        nxt_st.polarity = 1'b0;
        if (driver_enable_bit && mux_ok)
        begin
          nxt_st.run = lcdfb_pkg::LCDFB_ST_RUN;
        end
      end
      lcdfb_pkg::LCDFB_ST_RUN:
      begin
        if (!driver_enable_bit || !mux_ok)
        begin
          nxt_st.run = lcdfb_pkg::LCDFB_ST_IDLE;
        end
        else if (src_edge)
        begin
          if (st_ff.div_cnt >= div_now - 8'h01)
          begin
            nxt_st.div_cnt = 8'h00;
            nxt_st.drive_tick = 1'b1;
            if (st_ff.phase >= last_phase(multiplex_level))
            begin
              nxt_st.phase = 2'h0;
              nxt_st.frame_start = 1'b1;
              nxt_st.polarity = st_ff.frame_invert_en & ~st_ff.polarity;
              if (!st_ff.refresh_hold)
              begin
                nxt_st.load = 1'b1;
                if (st_ff.update_pending)
                begin
                  nxt_st.update_finished_flag = 1'b1;
                  nxt_st.update_pending = 1'b0;
                end
              end
            end
            else
            begin
              nxt_st.phase = st_ff.phase + 2'h1;
            end
          end
          else
          begin
            nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
          end
        end
      end
      default:
      begin
        nxt_st.run = lcdfb_pkg::LCDFB_ST_IDLE;
      end
    endcase

    // hardware blink pacing on the 128 hz source
    if (!blink_enable_bit || !blinking)
    begin
      nxt_st.blink_cnt = 9'h000;
      nxt_st.blink_on = 1'b1;
    end
    else if (lo_edge)
    begin
      if (st_ff.blink_cnt >= blink_half(st_ff.clkcfg.blink_source_sel,
                                        st_ff.clkcfg.blink_rate_sel) - 9'h001)
      begin
        nxt_st.blink_cnt = 9'h000;
        nxt_st.blink_on = ~st_ff.blink_on;
      end
      else
      begin
        nxt_st.blink_cnt = st_ff.blink_cnt + 9'h001;
      end
    end
  end

  // register the whole state; reset leaves the blink phase on
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.clkcfg <= lcdfb_pkg::LCDFB_RST_CLK_BLINK;
      st_ff.run <= lcdfb_pkg::LCDFB_ST_IDLE;
      st_ff.blink_on <= 1'b1;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  logic visible;

  // blanking: software codes or the hardware blink phase
  always_comb
  begin
    visible = 1'b1;
    if (blink_enable_bit)
    begin
      case (st_ff.clkcfg.blink_source_sel)
        lcdfb_pkg::LCDFB_BLK_SW_OFF: visible = 1'b0;
        lcdfb_pkg::LCDFB_BLK_SW_ON:  visible = 1'b1;
        default:                     visible = st_ff.blink_on;
      endcase
    end
  end

  // display data copy, refreshed at frame starts outside hold
  lcdfb_shadow u_shadow (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .load    (st_ff.load),
    .din     (display_data),
    .dout    (seg_data)
  );

  // one driver fills the whole timing bundle, msb first
  assign sfr_rdata = st_ff.rdata;
  assign timing    = {st_ff.drive_tick, st_ff.phase, st_ff.frame_start, st_ff.polarity,
                      visible & (st_ff.run == lcdfb_pkg::LCDFB_ST_RUN),
                      st_ff.run == lcdfb_pkg::LCDFB_ST_RUN};

endmodule
`default_nettype wire

/* tb/lcdfb_props.sv */
`timescale 1ns/1ps
`default_nettype none
module lcdfb_props (
  input wire logic                              clk_sys,
  input wire logic                              resetn,
  input wire logic                              ce,
  input wire logic [7:0]                        sfr_addr,
  input wire logic [7:0]                        sfr_wdata,
  input wire logic                              sfr_wr,
  input wire logic                              sfr_rd,
  input wire logic [7:0]                        sfr_rdata,
  input wire logic                              driver_enable_bit,
  input wire logic                              blink_enable_bit,
  input wire logic [1:0]                        multiplex_level,
  input wire logic [lcdfb_pkg::LCDFB_SEG_W-1:0] display_data,
  input wire lcdfb_pkg::lcdfb_timing_t          timing,
  input wire logic [lcdfb_pkg::LCDFB_SEG_W-1:0] seg_data
);
  logic [7:0] cfg_ff;
  logic       hold_ff;
  // mirror of the clock and blink register and of the hold bit
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_ff  <= 8'h00;
      hold_ff <= 1'b0;
    end
    else if (ce && sfr_wr)
    begin
      if (sfr_addr == lcdfb_pkg::LCDFB_ADDR_CLK_BLINK)
        cfg_ff <= sfr_wdata;
      if (sfr_addr == lcdfb_pkg::LCDFB_ADDR_INV_REF)
        hold_ff <= sfr_wdata[0];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // timing checks
  chk_idle_no_tick:
    assert property ((ce && (!driver_enable_bit || multiplex_level == 2'h0))[*3]
      |-> !timing.drive_tick && !timing.waveform_active) else $error("tick while idle");
  chk_pol_at_frame:
    assert property ($changed(timing.frame_polarity)
      |-> timing.frame_start || !timing.waveform_active) else $error("polarity moved");
  chk_seg_at_frame:
    assert property ($changed(seg_data) |-> $past(timing.frame_start))
      else $error("segment data moved off frame");
  chk_seg_takeover:
    assert property (timing.frame_start && !hold_ff && !$past(hold_ff)
      |=> seg_data == $past(display_data)) else $error("segment data not taken");
  chk_seg_held:
    assert property (timing.frame_start && hold_ff && $past(hold_ff) |=> $stable(seg_data))
      else $error("segment data used under hold");
  chk_cfg_readback:
    assert property (ce && sfr_rd && sfr_addr == lcdfb_pkg::LCDFB_ADDR_CLK_BLINK
      |=> sfr_rdata == $past(cfg_ff)) else $error("config read wrong");
  chk_frame_wrap:
    assert property (timing.frame_start |-> timing.drive_tick && timing.com_phase == 2'h0)
      else $error("frame start off wrap");
  chk_frame_ticks:
    assert property (timing.frame_start && $past(timing.waveform_active)
      |-> $past(timing.com_phase) == multiplex_level) else $error("frame tick count");
  chk_sw_blank:
    assert property ((ce && blink_enable_bit && cfg_ff[7:6] == 2'h0)[*2]
      |-> !timing.display_visible) else $error("display not blanked");
  chk_steady_show:
    assert property ((ce && timing.waveform_active
      && (!blink_enable_bit || cfg_ff[7:6] == 2'h1))[*3] |-> timing.display_visible)
      else $error("display not shown");
  // main scenarios
  cov_inverted: cover property (timing.frame_start && timing.frame_polarity);
  cov_held: cover property (timing.frame_start && hold_ff);
  cov_blinked: cover property ($fell(timing.display_visible) && blink_enable_bit);
endmodule
bind lcdfb_timing lcdfb_props u_props (
  .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .driver_enable_bit(driver_enable_bit), .blink_enable_bit(blink_enable_bit),
  .multiplex_level(multiplex_level), .display_data(display_data),
  .timing(timing), .seg_data(seg_data)
);
`default_nettype wire

/* tb/lcdfb_glass.sv */
`timescale 1ns/1ps
`default_nettype none
module lcdfb_glass (
  input wire logic                               clk_sys,
  input wire lcdfb_pkg::lcdfb_timing_t           timing,
  input wire logic [lcdfb_pkg::LCDFB_SEG_W-1:0]  seg_data,
  output logic     [31:0]                        frames,
  output logic     [lcdfb_pkg::LCDFB_SEG_W-1:0]  shown
);
  logic pend;
  // the glass counts frames and shows the image latched after each start
  initial
  begin
    frames = 0;
    shown = '0;
    pend = 1'b0;
  end
  always @(posedge clk_sys)
  begin
    pend <= timing.frame_start;
    if (timing.frame_start)
      frames <= frames + 1;
    if (pend)
      shown <= timing.display_visible ? seg_data : '0; // blanked glass shows nothing
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 0, resetn = 0, ce = 1, sfr_wr = 0, sfr_rd = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
  logic driver_enable_bit = 0, blink_enable_bit = 0, source_clock_select = 0;
  logic [1:0] multiplex_level = 2'h1;
  logic lcd_clk_2048 = 0, lcd_clk_128 = 0;
  logic [31:0] display_data = 0, seg_data, frames, shown;
  lcdfb_pkg::lcdfb_timing_t timing;
  int n_mismatch = 0, num_checks = 0, cyc = 0, n2048 = 0, n128 = 0, i, c0;
  logic p;
  lcdfb_timing dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .driver_enable_bit(driver_enable_bit), .blink_enable_bit(blink_enable_bit),
    .source_clock_select(source_clock_select), .multiplex_level(multiplex_level),
    .lcd_clk_2048(lcd_clk_2048), .lcd_clk_128(lcd_clk_128),
    .display_data(display_data), .timing(timing), .seg_data(seg_data));
  lcdfb_glass glass (.clk_sys(clk_sys), .timing(timing), .seg_data(seg_data),
    .frames(frames), .shown(shown));
  // system clock and two fast stand-ins for the lcd source clocks
  initial forever #25 clk_sys = ~clk_sys;
  initial forever #160 lcd_clk_2048 = ~lcd_clk_2048;
  initial forever #210 lcd_clk_128 = ~lcd_clk_128;
  always @(posedge lcd_clk_2048) n2048++;
  always @(posedge lcd_clk_128) n128++;
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // a hang is cut short here
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one strobe cycle per register access, driven on falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    cmp("register read", {24'h0, exp}, {24'h0, sfr_rdata});
  endtask
  // kind 0 waits for a drive tick, kind 1 for a frame start
  task automatic wait_ev(input int kind);
    bit hit;
    hit = 1'b0;
    for (int k = 0; k < 20000 && !hit; k++)
    begin
      @(negedge clk_sys);
      hit = (kind == 0 ? timing.drive_tick : timing.frame_start) === 1'b1;
    end
    cmp("timing event seen", 32'h1, {31'h0, hit});
  endtask
  task automatic wait_vis();
    logic v;
    bit hit;
    v = timing.display_visible;
    hit = 1'b0;
    for (int k = 0; k < 20000 && !hit; k++)
    begin
      @(negedge clk_sys);
      hit = (timing.display_visible !== v);
    end
    cmp("visibility change", 32'h1, {31'h0, hit});
  endtask
  // source edges between two drive ticks
  task automatic measure(input logic sel, input logic [1:0] mux, input logic [3:0] code,
                         input int exp_d);
    driver_enable_bit = 1'b0;
    wr(8'h96, {4'h0, code});
    source_clock_select = sel;
    multiplex_level = mux;
    driver_enable_bit = 1'b1;
    wait_ev(0);
    c0 = sel ? n128 : n2048;
    wait_ev(0);
    cmp("drive period", 32'(exp_d), 32'((sel ? n128 : n2048) - c0));
  endtask
  // blink half period in 128 hz edges
  task automatic blink(input logic [1:0] src, input logic [1:0] rate, input int exp_e);
    wr(8'h96, {src, rate, 4'hf});
    wait_vis();
    c0 = n128;
    wait_vis();
    cmp("blink half period", 32'(exp_e), 32'(n128 - c0));
  endtask
  initial
  begin
    repeat (20) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(8'h96, 8'h00);
    rd(8'hb1, 8'h00);
    wr(8'h96, 8'ha5);
    rd(8'h96, 8'ha5);
    wr(8'hb1, 8'h43);
    rd(8'hb1, 8'h41);
    wr(8'h97, 8'hff);
    rd(8'h97, 8'h00);
    wr(8'hb1, 8'h00);
    measure(0, 2'h1, 4'h0, 128);
    measure(0, 2'h1, 4'h3, 16);
    measure(0, 2'h2, 4'h0, 64);
    measure(0, 2'h2, 4'h1, 6);
    measure(0, 2'h3, 4'h1, 4);
    measure(0, 2'h2, 4'h7, 16);
    measure(1, 2'h1, 4'h1, 4);
    measure(1, 2'h1, 4'h2, 6);
    measure(1, 2'h3, 4'h5, 4);
    measure(1, 2'h2, 4'h0, 2);
    measure(1, 2'h1, 4'hf, 1);
    // refresh hold and update flag
    display_data = 32'h1234_5678;
    wait_ev(1);
    repeat (3) @(negedge clk_sys);
    cmp("shown image", 32'h1234_5678, shown);
    wr(8'hb1, 8'h01);
    wait_ev(1);
    display_data = 32'hcafe_0001;
    wait_ev(1);
    @(negedge clk_sys);
    cmp("segment data", 32'h1234_5678, seg_data);
    wr(8'hb1, 8'h00);
    wait_ev(1);
    repeat (2) @(negedge clk_sys);
    cmp("segment data", 32'hcafe_0001, seg_data);
    rd(8'hb1, 8'h02);
    wr(8'hb1, 8'h01);
    rd(8'hb1, 8'h01);
    wr(8'hb1, 8'h00);
    // polarity stays put, then flips each frame
    for (i = 0; i < 2; i++)
    begin
      wait_ev(1);
      cmp("frame polarity", 32'h0, {31'h0, timing.frame_polarity});
    end
    wr(8'hb1, 8'h40);
    wait_ev(1);
    p = timing.frame_polarity;
    c0 = frames;
    wait_ev(1);
    cmp("frame polarity", {31'h0, ~p}, {31'h0, timing.frame_polarity});
    cmp("glass frames", 32'h1, 32'(frames - c0));
    // stopped timing
    driver_enable_bit = 1'b0;
    repeat (3) @(negedge clk_sys);
    cmp("waveform active", 32'h0, {31'h0, timing.waveform_active});
    driver_enable_bit = 1'b1;
    multiplex_level = 2'h0;
    repeat (3) @(negedge clk_sys);
    cmp("waveform active", 32'h0, {31'h0, timing.waveform_active});
    multiplex_level = 2'h3;
    // blinking
    blink_enable_bit = 1'b1;
    wr(8'h96, 8'h0f);
    repeat (3) @(negedge clk_sys);
    cmp("display visible", 32'h0, {31'h0, timing.display_visible});
    wr(8'h96, 8'h4f);
    repeat (3) @(negedge clk_sys);
    cmp("display visible", 32'h1, {31'h0, timing.display_visible});
    blink_enable_bit = 1'b0;
    wr(8'h96, 8'h0f);
    repeat (3) @(negedge clk_sys);
    cmp("display visible", 32'h1, {31'h0, timing.display_visible});
    blink_enable_bit = 1'b1;
    blink(2'h2, 2'h0, 32);
    for (i = 0; i < 4; i++)
      blink(2'h3, 2'(i), 64 * (i + 1));
    close_out();
  end
endmodule
`default_nettype wire
